/* File: pes_pkg.sv */
// package: constants and types of the performance event select and decode block
`default_nettype none
package pes_pkg;
  localparam int ADDR_W = 5;
  localparam int N_CNT  = 2;
  // register map (byte addresses); counter i at OFF_CTL0 + i*OFF_STRIDE
  localparam int OFF_CTL0   = 'h00;
  localparam int OFF_CNT0   = 'h04;
  localparam int OFF_STRIDE = 'h08;
  localparam int OFF_STATUS = 'h10;
  // control word fields
  localparam int CTL_W        = 17;
  localparam int CTL_CODE_LSB = 0;
  localparam int CTL_QUAL_LSB = 8;
  localparam int CTL_EN_BIT   = 16;
  localparam logic [CTL_W-1:0] CTL_RST = 17'h00000;
  localparam logic [31:0]      CNT_RST = 32'h00000000;
  // status word fields
  localparam int ST_GRAN64_BIT  = 0;
  localparam int ST_PENALTY_BIT = 1;
  // event codes
  localparam logic [7:0] EV_NET_STALL   = 8'hd1;
  localparam logic [7:0] EV_STALL_FIRST = 8'hd2;
  localparam logic [7:0] EV_LS_FULL     = 8'hd8;
  localparam logic [7:0] EV_ALL_QUIET   = 8'hd9;
  localparam logic [7:0] EV_FAR_DRAIN   = 8'hda;
  localparam logic [7:0] EV_FPU         = 8'hdb;
  localparam logic [7:0] EV_BP_FIRST    = 8'hdc;
  localparam logic [7:0] EV_BP_LAST     = 8'hdf;
  localparam logic [7:0] EV_DRAM        = 8'he0;
  localparam logic [7:0] EV_PT_OVF      = 8'he1;
  localparam logic [7:0] EV_TURN        = 8'he3;
  localparam logic [7:0] EV_BYPASS      = 8'he4;
  localparam logic [7:0] EV_SIZED       = 8'he5;
  localparam logic [7:0] EV_THERM       = 8'he8;
  localparam logic [7:0] EV_FLOW        = 8'he9;
  // stall cause indices (code minus EV_STALL_FIRST)
  localparam int STALL_LS    = 6;
  localparam int STALL_QUIET = 7;
  localparam int STALL_FAR   = 8;
  // request-flow qualifier positions
  localparam int FLOW_TO_REM   = 4;
  localparam int FLOW_TO_LOC   = 5;
  localparam int FLOW_FROM_REM = 6;
  localparam int FLOW_FROM_LOC = 7;
  localparam logic [3:0] FLOW_MEM_TYPES = 4'ha;
  localparam int SIZED_LSB = 2;
  localparam int ECC_BIT   = 7;
  localparam logic [6:0] BP_PENALTY_CYC = 7'h78;

  typedef struct packed {
    logic [8:0] stall;
    logic [3:0] fpu;
    logic [3:0] bp_match;
    logic [3:0] bp_instr;
    logic [2:0] dram;
    logic       gran64;
    logic       pt_ovf;
    logic [2:0] turn;
    logic [3:0] bypass;
    logic [3:0] sized;
    logic       sized_cpu_wc;
    logic       sized_host;
    logic [3:0] therm;
    logic [1:0] ecc;
    logic       req_v;
    logic [3:0] req_type;
    logic       req_src_rem;
    logic       req_dst_rem;
  } pes_ev_s;
endpackage
`default_nettype wire

/* File: pes_top.sv */
// module: event select decode, counters, breakpoint penalty and register slave
// Contract
// R1 - D8h counts cycles load/store unit is full
// R2 - D9h counts cycles waiting for all quiet
// R3 - DAh counts far transfer or restart drain
// R4 - DBh counts selected floating-point assist classes
// R5 - DCh-DFh count debug compare matches, even disabled
// R6 - instruction breakpoint match costs 120 cycles; code charges it only when an enabled counter selects that DCh-DFh code
// R7 - E0h counts DRAM page hit, miss, conflict
// R8 - access means 64 or 32 byte block
// R9 - E1 counts open page table overflows
// R10 - E3 counts selected DRAM bus turnarounds
// R11 - E4h counts selected bypass counter saturations
// R12 - E5 counts 32/64 byte sized transfers only
// R13 - processor sized transfers come from flushes only
// R14 - E8h counts thermal clocks and ECC errors
// R15 - software selects type, source and target
// R16 - flow qualifier bits encode types and locations
// R17 - software uses only supported combined values
// R18 - ORed flow qualifiers count the union
// R19 - one count per request, reads and writes alike
// R20 - D1h counts net stall cycles once
// R21 - count only selected event with enabled qualifier
// R22 - cycles add one, occurrences summed per clock
//
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`default_nettype none
module pes_top (
  input  wire logic                         CLK,
  input  wire logic                         NRST,
  input  wire logic [pes_pkg::ADDR_W-1:0]   AVS_ADDRESS,
  input  wire logic                         AVS_READ,
  input  wire logic                         AVS_WRITE,
  input  wire logic [31:0]                  AVS_WRITEDATA,
  output logic      [31:0]                  AVS_READDATA,
  output logic                              AVS_WAITREQUEST,
  input  wire pes_pkg::pes_ev_s             EV,
  output logic                              BP_PENALTY
);
  localparam int AW = pes_pkg::ADDR_W;
  localparam int NC = pes_pkg::N_CNT;

  logic                                 wait_reg;
  logic [31:0]                          rdata_reg;
  logic                                 wr_acc;
  logic [31:0]                          rd_next;
  logic [NC-1:0][pes_pkg::CTL_W-1:0]    ctl_w;
  logic [NC-1:0][31:0]                  cnt_w;
  logic [NC-1:0]                        bp_hit;
  logic [6:0]                           pen_cnt_reg;
  logic [6:0]                           pen_cnt_next;
  logic                                 pen_reg;
  logic                                 gran_reg;

  // per-clock increment for one counter
  function automatic logic [3:0] ev_count(input logic [7:0] c, input logic [7:0] q, input pes_pkg::pes_ev_s e);
    logic [7:0] m;
    logic [3:0] t;
    logic [3:0] n;
    m = '0;
    t = '0;
    n = '0;
    if (c >= pes_pkg::EV_STALL_FIRST && c <= pes_pkg::EV_FAR_DRAIN) begin
      m[0] = e.stall[4'(c - pes_pkg::EV_STALL_FIRST)]; // [R1] [R2] [R3]
    end else if (c >= pes_pkg::EV_BP_FIRST && c <= pes_pkg::EV_BP_LAST) begin
      // enable bits of the breakpoint control are not looked at
      m[0] = e.bp_match[2'(c - pes_pkg::EV_BP_FIRST)]; // [R5]
    end else begin
      case (c)
        pes_pkg::EV_NET_STALL: m[0] = |e.stall; // [R20]
        pes_pkg::EV_FPU:       m = {4'h0, q[3:0] & e.fpu}; // [R4]
        pes_pkg::EV_DRAM:      m = {5'h00, q[2:0] & e.dram}; // [R7]
        pes_pkg::EV_PT_OVF:    m[0] = e.pt_ovf; // [R9]
        pes_pkg::EV_TURN:      m = {5'h00, q[2:0] & e.turn}; // [R10]
        pes_pkg::EV_BYPASS:    m = {4'h0, q[3:0] & e.bypass}; // [R11]
        pes_pkg::EV_SIZED: begin
          // processor side only reports write-combining flushes
          if (e.sized_host || e.sized_cpu_wc) begin // [R13]
            m = {2'h0, q[pes_pkg::SIZED_LSB+3:pes_pkg::SIZED_LSB] & e.sized, 2'h0}; // [R12]
          end
        end
        pes_pkg::EV_THERM: begin
          m[3:0] = q[3:0] & e.therm; // [R14]
          m[5:4] = q[pes_pkg::ECC_BIT] ? e.ecc : 2'h0; // [R14]
        end
        pes_pkg::EV_FLOW: begin
          // remote sources never reach memory or remote targets, so such paths drop out
          t = q[3:0] & e.req_type & (e.req_src_rem ? ~pes_pkg::FLOW_MEM_TYPES : 4'hf); // [R16] [R17]
          m[0] = e.req_v && (|t) // [R18] [R19]
                 && (e.req_dst_rem ? q[pes_pkg::FLOW_TO_REM] : q[pes_pkg::FLOW_TO_LOC])
                 && (e.req_src_rem ? (q[pes_pkg::FLOW_FROM_REM] && !e.req_dst_rem)
                                   : q[pes_pkg::FLOW_FROM_LOC]); // [R15]
        end
        default: m = '0;
      endcase
    end
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, m[i]}; // [R22]
    end
    return n;
  endfunction

  assign wr_acc          = AVS_WRITE && !wait_reg;
  assign AVS_WAITREQUEST = wait_reg;
  assign AVS_READDATA    = rdata_reg;
  assign BP_PENALTY      = pen_reg;

  // one wait cycle per access keeps read data a registered mux
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= !((AVS_READ || AVS_WRITE) && wait_reg);
    end
  end

  always_comb begin
    rd_next = '0;
    for (int i = 0; i < NC; i++) begin
      if (AVS_ADDRESS == AW'(pes_pkg::OFF_CTL0 + i * pes_pkg::OFF_STRIDE)) begin
        rd_next = {15'h0000, ctl_w[i]};
      end
      if (AVS_ADDRESS == AW'(pes_pkg::OFF_CNT0 + i * pes_pkg::OFF_STRIDE)) begin
        rd_next = cnt_w[i];
      end
    end
    if (AVS_ADDRESS == AW'(pes_pkg::OFF_STATUS)) begin
      rd_next[pes_pkg::ST_GRAN64_BIT]  = gran_reg; // [R8]
      rd_next[pes_pkg::ST_PENALTY_BIT] = pen_reg;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      rdata_reg <= 32'h00000000;
    end else if (AVS_READ && wait_reg) begin
      rdata_reg <= rd_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      gran_reg <= 1'b0;
    end else begin
      gran_reg <= EV.gran64; // [R8]
    end
  end

  for (genvar g = 0; g < NC; g++) begin : g_cnt
    localparam logic [AW-1:0] A_CTL = AW'(pes_pkg::OFF_CTL0 + g * pes_pkg::OFF_STRIDE);
    localparam logic [AW-1:0] A_CNT = AW'(pes_pkg::OFF_CNT0 + g * pes_pkg::OFF_STRIDE);
    logic [pes_pkg::CTL_W-1:0] ctl_reg;
    logic [31:0]               cnt_reg;
    logic [7:0]                code;
    logic [7:0]                qual;
    logic [3:0]                inc;
    assign code     = ctl_reg[pes_pkg::CTL_CODE_LSB+7:pes_pkg::CTL_CODE_LSB];
    assign qual     = ctl_reg[pes_pkg::CTL_QUAL_LSB+7:pes_pkg::CTL_QUAL_LSB];
    assign inc      = ctl_reg[pes_pkg::CTL_EN_BIT] ? ev_count(code, qual, EV) : 4'h0; // [R21]
    assign ctl_w[g] = ctl_reg;
    assign cnt_w[g] = cnt_reg;
    assign bp_hit[g] = ctl_reg[pes_pkg::CTL_EN_BIT] && code >= pes_pkg::EV_BP_FIRST
                       && code <= pes_pkg::EV_BP_LAST
                       && EV.bp_match[2'(code - pes_pkg::EV_BP_FIRST)]
                       && EV.bp_instr[2'(code - pes_pkg::EV_BP_FIRST)]; // [R6]
    always_ff @(posedge CLK) begin
      if (!NRST) begin
        ctl_reg <= pes_pkg::CTL_RST;
      end else if (wr_acc && AVS_ADDRESS == A_CTL) begin
        ctl_reg <= AVS_WRITEDATA[pes_pkg::CTL_W-1:0];
      end
    end
    // a software write wins over the increment of the same clock
    always_ff @(posedge CLK) begin
      if (!NRST) begin
        cnt_reg <= pes_pkg::CNT_RST;
      end else if (wr_acc && AVS_ADDRESS == A_CNT) begin
        cnt_reg <= AVS_WRITEDATA;
      end else begin
        cnt_reg <= cnt_reg + {28'h0000000, inc}; // [R22]
      end
    end
  end

  // load/store matches never load the penalty timer
  always_comb begin
    if (|bp_hit) begin
      pen_cnt_next = pes_pkg::BP_PENALTY_CYC; // [R6]
    end else if (pen_cnt_reg != 7'h00) begin
      pen_cnt_next = pen_cnt_reg - 7'h01;
    end else begin
      pen_cnt_next = 7'h00;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      pen_cnt_reg <= 7'h00;
      pen_reg     <= 1'b0;
    end else begin
      pen_cnt_reg <= pen_cnt_next;
      pen_reg     <= (pen_cnt_next != 7'h00); // [R6]
    end
  end

  // checks on counter 0, the breakpoint penalty and the bus wait cycle
  logic        c0_en;
  logic        c0_hold;
  logic [7:0]  c0_code;
  logic [7:0]  c0_q;
  logic [31:0] c0_cnt;
  assign c0_en   = g_cnt[0].ctl_reg[pes_pkg::CTL_EN_BIT];
  assign c0_code = g_cnt[0].code;
  assign c0_q    = g_cnt[0].qual;
  assign c0_cnt  = g_cnt[0].cnt_reg;
  assign c0_hold = !(wr_acc && AVS_ADDRESS == AW'(pes_pkg::OFF_CNT0));

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  property p_ls_full;
    c0_en && c0_hold && c0_code == pes_pkg::EV_LS_FULL && EV.stall[pes_pkg::STALL_LS] |=> c0_cnt == $past(c0_cnt) + 1;
  endproperty
  a_ls_full: assert property (p_ls_full) else $error("ls full stall not counted"); // [R1]

  property p_quiet;
    c0_en && c0_hold && c0_code == pes_pkg::EV_ALL_QUIET && !EV.stall[pes_pkg::STALL_QUIET] |=> $stable(c0_cnt);
  endproperty
  a_quiet: assert property (p_quiet) else $error("all quiet counted while idle"); // [R2]

  property p_far;
    c0_en && c0_hold && c0_code == pes_pkg::EV_FAR_DRAIN && EV.stall[pes_pkg::STALL_FAR]
      |=> c0_cnt == $past(c0_cnt) + 1;
  endproperty
  a_far: assert property (p_far) else $error("far drain stall missed"); // [R3]

  property p_fpu_none;
    c0_hold && c0_code == pes_pkg::EV_FPU && c0_q == 8'h00 |=> $stable(c0_cnt);
  endproperty
  a_fpu_none: assert property (p_fpu_none) else $error("assist counted with empty mask"); // [R4]

  property p_net;
    c0_en && c0_hold && c0_code == pes_pkg::EV_NET_STALL && (|EV.stall) |=> c0_cnt == $past(c0_cnt) + 1;
  endproperty
  a_net: assert property (p_net) else $error("net stall not counted once"); // [R20]

  property p_dram;
    c0_en && c0_hold && c0_code == pes_pkg::EV_DRAM && c0_q == 8'h07
      |=> c0_cnt == $past(c0_cnt) + $countones($past(EV.dram));
  endproperty
  a_dram: assert property (p_dram) else $error("dram outcomes not summed"); // [R7]

  property p_flow_rr;
    c0_hold && c0_code == pes_pkg::EV_FLOW && EV.req_src_rem && EV.req_dst_rem |=> $stable(c0_cnt);
  endproperty
  a_flow_rr: assert property (p_flow_rr) else $error("remote to remote request counted"); // [R17]

  property p_flow_rem_mem;
    c0_hold && c0_code == pes_pkg::EV_FLOW && EV.req_src_rem && !(|(EV.req_type & ~pes_pkg::FLOW_MEM_TYPES))
      |=> $stable(c0_cnt);
  endproperty
  a_flow_rem_mem: assert property (p_flow_rem_mem) else $error("remote source memory request counted"); // [R17]

  property p_sized_src;
    c0_hold && c0_code == pes_pkg::EV_SIZED && !EV.sized_host && !EV.sized_cpu_wc |=> $stable(c0_cnt);
  endproperty
  a_sized_src: assert property (p_sized_src) else $error("sized transfer counted without a source"); // [R13]

  property p_off;
    !c0_en && c0_hold |=> $stable(c0_cnt);
  endproperty
  a_off: assert property (p_off) else $error("disabled counter moved"); // [R21]

  property p_unknown;
    c0_hold && c0_code > pes_pkg::EV_FLOW |=> $stable(c0_cnt);
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown event code counted"); // [R21]

  property p_bp0;
    c0_en && c0_hold && c0_code == pes_pkg::EV_BP_FIRST && EV.bp_match[0] |=> c0_cnt == $past(c0_cnt) + 1;
  endproperty
  a_bp0: assert property (p_bp0) else $error("debug compare match not counted"); // [R5]

  property p_pen_rise;
    !BP_PENALTY && !(|bp_hit) |=> !BP_PENALTY;
  endproperty
  a_pen_rise: assert property (p_pen_rise) else $error("penalty raised without instruction match"); // [R6]

  sequence s_last_tick;
    pen_cnt_reg == 7'h01 && !(|bp_hit);
  endsequence
  property p_pen_end;
    s_last_tick |=> !BP_PENALTY;
  endproperty
  a_pen_end: assert property (p_pen_end) else $error("penalty outlasted its count"); // [R6]

  sequence s_instr_hit;
    |bp_hit;
  endsequence
  sequence s_penalty;
    BP_PENALTY [*8];
  endsequence
  property p_pen;
    s_instr_hit |=> s_penalty;
  endproperty
  a_pen: assert property (p_pen) else $error("breakpoint penalty not held"); // [R6]

  property p_wait;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer not one cycle");
endmodule
`default_nettype wire

/* File: tb.sv */
// testbench: self-checking bench of the event select and decode block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [4:0]       adr;
    logic [16:0]      ctl;
    pes_pkg::pes_ev_s ev;
    int               n;
    logic [31:0]      exp;
  } pes_row_s;
  logic             clk, nrst, rd, wr, waitreq, pen;
  logic [4:0]       adr;
  logic [31:0]      wdata, rdata, q;
  pes_pkg::pes_ev_s ev, e;
  pes_row_s         rows[$];
  int               bad_count, n_checks, h;

  pes_top pes_top_inst (.CLK(clk), .NRST(nrst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .EV(ev), .BP_PENALTY(pen));

  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // holds the request until waitrequest is seen low or 50 cycles pass; the slave latency is never assumed
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    int t;
    @(posedge clk);
    adr   <= a;
    wdata <= d;
    wr    <= w;
    rd    <= ~w;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (waitreq !== 1'h0 && t < 50);
    if (t >= 50) chk(32'hdead, 32'h0);
    r = rdata;
    wr <= 1'h0;
    rd <= 1'h0;
  endtask

  task automatic add(input logic [4:0] a, input logic [16:0] c, input int n, input logic [31:0] x);
    rows.push_back('{a, c, e, n, x});
    e = '0;
  endtask

  task automatic pulse_bp(input logic instr);
    @(posedge clk) begin
      ev.bp_match <= 4'h1;
      ev.bp_instr <= {3'h0, instr};
    end
    @(posedge clk) ev <= '0;
    h = 0;
    repeat (130) @(posedge clk) h += int'(pen === 1'h1);
  endtask

  initial begin
    #2000000;
    bad_count++;
    print_verdict();
  end

  initial begin
    nrst = 1'h0; rd = 1'h0; wr = 1'h0; adr = 5'h00; wdata = 32'h0; ev = '0; e = '0;
    bad_count = 0; n_checks = 0;
    e.stall[6] = 1'h1;   add(5'h00, 17'h100d8, 3, 32'h3);
    e.stall[7] = 1'h1;   add(5'h00, 17'h100d9, 2, 32'h2);
    e.stall[8] = 1'h1;   add(5'h08, 17'h100da, 4, 32'h4);
    e.stall = 9'h1c0;    add(5'h00, 17'h100d1, 3, 32'h3);
    e.fpu = 4'hf;        add(5'h00, 17'h105db, 3, 32'h6);
    e.fpu = 4'hf;        add(5'h00, 17'h100db, 2, 32'h0);
    e.bp_match = 4'h2;   add(5'h08, 17'h100dd, 2, 32'h2);
    e.bp_match = 4'h7;   add(5'h00, 17'h100df, 2, 32'h0);
    e.dram = 3'h7;       add(5'h00, 17'h102e0, 3, 32'h3);
    e.dram = 3'h7;       add(5'h00, 17'h100e0, 3, 32'h0);
    e.dram = 3'h5;       add(5'h00, 17'h107e0, 2, 32'h4);
    e.pt_ovf = 1'h1;     add(5'h00, 17'h100e1, 2, 32'h2);
    e.turn = 3'h7;       add(5'h00, 17'h106e3, 2, 32'h4);
    e.bypass = 4'hf;     add(5'h00, 17'h109e4, 2, 32'h4);
    e.sized = 4'hf; e.sized_host = 1'h1; add(5'h00, 17'h124e5, 2, 32'h4);
    e.sized = 4'hf;      add(5'h00, 17'h13ce5, 2, 32'h0);
    e.therm = 4'h1; e.ecc = 2'h3; add(5'h08, 17'h181e8, 2, 32'h6);
    e.req_v = 1'h1; e.req_type = 4'h8; add(5'h00, 17'h1a8e9, 3, 32'h3);
    e.req_v = 1'h1; e.req_type = 4'h4; e.req_src_rem = 1'h1; add(5'h00, 17'h164e9, 2, 32'h2);
    e.req_v = 1'h1; e.req_type = 4'h8; e.req_dst_rem = 1'h1; add(5'h00, 17'h1b8e9, 2, 32'h2);
    e.req_v = 1'h1; e.req_type = 4'hf; e.req_src_rem = 1'h1; e.req_dst_rem = 1'h1; add(5'h00, 17'h1ffe9, 2, 32'h0);
    e.req_v = 1'h1; e.req_type = 4'ha; e.req_src_rem = 1'h1; add(5'h00, 17'h1ffe9, 2, 32'h0);
    e.stall[6] = 1'h1;   add(5'h00, 17'h000d8, 3, 32'h0);
    e = '1; e.gran64 = 1'h0; add(5'h00, 17'h1ffe2, 2, 32'h0);
    repeat (20) @(posedge clk);
    nrst <= 1'h1;
    foreach (rows[i]) begin
      if (i == 0) for (int a = 0; a < 20; a += 4) begin
        bus(1'h0, 5'(a), 32'h0, q);
        chk(q, 32'h0);
      end
      bus(1'h1, rows[i].adr, 32'(rows[i].ctl), q);
      bus(1'h1, rows[i].adr + 5'h04, 32'h0, q);
      repeat (rows[i].n) @(posedge clk) ev <= rows[i].ev;
      @(posedge clk) ev <= '0;
      bus(1'h0, rows[i].adr + 5'h04, 32'h0, q);
      chk(q, rows[i].exp);
    end
    // awkward cases: control width, unmapped place, breakpoint penalty, status, reset in mid-run
    bus(1'h1, 5'h00, 32'hffffffff, q);
    bus(1'h0, 5'h00, 32'h0, q);
    chk(q, 32'h0001ffff);
    bus(1'h1, 5'h14, 32'hffffffff, q);
    bus(1'h0, 5'h14, 32'h0, q);
    chk(q, 32'h0);
    bus(1'h1, 5'h00, 32'h000100dc, q);
    pulse_bp(1'h0);
    chk(32'(h), 32'h0);
    pulse_bp(1'h1);
    chk(32'(h), 32'd120);
    @(posedge clk) ev.gran64 <= 1'h1;
    repeat (2) @(posedge clk);
    bus(1'h0, 5'h10, 32'h0, q);
    chk(q & 32'h3, 32'h1);
    @(posedge clk) nrst <= 1'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    bus(1'h0, 5'h00, 32'h0, q);
    chk(q, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
